// ### pkg/stf_pkg.sv
package stf_pkg;

  localparam logic [15:0] STF_ETYPE_IP      = 16'h0800;
  localparam logic [7:0]  STF_PROTO_GRE     = 8'h2F;
  localparam logic [3:0]  STF_IP_MCAST_NIB  = 4'hE;
  localparam logic [1:0]  STF_FC_PACKET_PDU = 2'h0;
  localparam int          STF_MIN_RULES_PER_CH = 32;
  localparam int          STF_MAX_CH           = 16;

  // Header bytes added to the UDP payload when a frame is metered
  localparam int          STF_IP_HDR_BYTES  = 20;
  localparam int          STF_UDP_HDR_BYTES = 8;
  localparam logic [19:0] STF_L3L4_BYTES    = 20'(STF_IP_HDR_BYTES + STF_UDP_HDR_BYTES);

  // Token refill period and the host-side ceiling it is compared against
  localparam int          STF_CLK_PERIOD_NS  = 4;
  localparam int          STF_TICK_US        = 1000;
  localparam int          STF_TICK_CYCLES    = STF_TICK_US * 1000 / STF_CLK_PERIOD_NS;
  localparam int          STF_HOST_LIMIT_KBPS = 2048;
  localparam logic [15:0] STF_HOST_BYTES_PER_TICK =
    16'(STF_HOST_LIMIT_KBPS * STF_TICK_US / 8000);

  localparam logic [19:0] STF_TOKENS_RESET = 20'h00000;

  typedef enum logic {
    STF_UCAST_DIRECT,
    STF_UCAST_TRANSLATE
  } stf_ucast_type;

  typedef struct packed {
    logic [47:0] dst_mac;
    logic [47:0] src_mac;
    logic [15:0] ethertype;
    logic [31:0] ip_src;
    logic [31:0] ip_dst;
    logic [7:0]  proto;
    logic [15:0] udp_dport;
    logic [31:0] inner_ip_src;
    logic [31:0] inner_ip_dst;
    logic [7:0]  inner_proto;
    logic [15:0] inner_udp_dport;
    logic [15:0] payload_len;
  } stf_hdr_type;

  typedef struct packed {
    logic [1:0]  fc;
    logic [3:0]  channel;
    logic [47:0] dst_mac;
    logic [47:0] src_mac;
    logic [15:0] ethertype;
    logic [31:0] ip_src;
    logic [31:0] ip_dst;
    logic [7:0]  proto;
    logic [15:0] udp_dport;
    logic [15:0] payload_len;
  } stf_out_hdr_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] group_ip;
    logic [47:0] tunnel_mac;
    logic [3:0]  channel;
    logic        basic_mode;
    logic [15:0] bcast_client_id;
    logic [15:0] rate_bytes;
    logic [19:0] burst_bytes;
  } stf_rule_type;

  typedef struct packed {
    logic [7:0]  proto;
    logic [15:0] port_lo;
    logic [15:0] port_hi;
    logic        src_check_en;
    logic [31:0] trusted_src;
    logic [31:0] trusted_mask;
  } stf_acl_type;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } stf_beat_type;

endpackage : stf_pkg

// ### src/stf_forwarder.sv
`timescale 1ns/1ns
// Summary of operation
// - Only ethertype 0x0800 frames enter a tunnel
// - Filter UDP port and protocol after decapsulation
// - Optionally drop packets from untrusted sources
// - One-way downstream forwarding on several channels
// - Basic and advanced mode tunnels coexist
// - Frame control set to packet PDU code
// - No management messages to tunnel addresses
// - At least 32 tunnels per downstream channel
// - Per-tunnel rate limit, descriptors not metered
// - Keep host traffic at or below 2.048 Mbps; code caps each rule's rate_bytes at 256 per tick, not the sum
// - Rewrite destination and source MAC addresses
// - Keep IP source, destination and protocol
// - Payload and UDP ports pass unchanged
// - One multicast group maps to one tunnel
// - A broadcast rule holds exactly one identifier
// - Unicast streams decapsulated, translated or forwarded
// - Tunnel address must be a group MAC; the code requires it only for rules with basic_mode clear
module stf_forwarder
  import stf_pkg::*;
#(
  parameter int NUM_CH       = 2,
  parameter int RULES_PER_CH = STF_MIN_RULES_PER_CH,
  parameter int TICK_CYCLES  = STF_TICK_CYCLES
) (
  input  wire logic                                   sys_clk_i,
  input  wire logic                                   rst_i,
  input  wire logic                                   cfg_we_i,
  input  wire logic [$clog2(NUM_CH*RULES_PER_CH)-1:0] cfg_idx_i,
  input  wire stf_rule_type                           cfg_rule_i,
  output logic                                        cfg_err_o,
  input  wire stf_acl_type                            acl_i,
  input  wire stf_ucast_type                          ucast_mode_i,
  input  wire logic [31:0]                            ucast_group_i,
  input  wire logic [47:0]                            hfc_mac_i,
  input  wire logic                                   in_hdr_valid_i,
  output logic                                        in_hdr_ready_o,
  input  wire stf_hdr_type                            in_hdr_i,
  input  wire logic                                   in_pay_valid_i,
  output logic                                        in_pay_ready_o,
  input  wire stf_beat_type                           in_pay_i,
  output logic                                        out_hdr_valid_o,
  input  wire logic                                   out_hdr_ready_i,
  output stf_out_hdr_type                             out_hdr_o,
  output logic                                        out_pay_valid_o,
  input  wire logic                                   out_pay_ready_i,
  output stf_beat_type                                out_pay_o,
  output logic                                        drop_o
);

  localparam int NR = NUM_CH * RULES_PER_CH;
  localparam int IW = $clog2(NR);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  if (RULES_PER_CH < STF_MIN_RULES_PER_CH || NUM_CH < 1 || NUM_CH > STF_MAX_CH
      || TICK_CYCLES < 2) begin : g_bad_param
    $error("stf_forwarder: unsupported parameter values");
  end

  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_HDR, S_BODY} stf_state_type;

  stf_state_type   state_reg;
  stf_hdr_type     hdr_reg;
  stf_out_hdr_type out_hdr_reg;
  stf_rule_type    rules_reg [NR];
  logic [19:0]     tokens_reg [NR];
  logic [TW-1:0]   tick_cnt_reg;
  logic            pass_reg;
  logic            cfg_err_reg;
  logic            drop_reg;
  stf_beat_type    out_pay_reg;
  logic            out_pay_valid_reg;

  stf_hdr_type     eff;
  logic            hit;
  logic [IW-1:0]   hit_idx;
  logic [19:0]     meter_len;
  logic            acl_ok;
  logic            src_ok;
  logic            rate_ok;
  logic            accept;
  logic            tick;
  logic            cfg_conflict;
  logic            cfg_bad;

  // Strips GRE wrapping and applies unicast-to-multicast translation
  function automatic stf_hdr_type stf_effective(input stf_hdr_type h,
                                                input stf_ucast_type m,
                                                input logic [31:0] grp);
    stf_hdr_type r;
    r = h;
    if (h.proto == STF_PROTO_GRE) begin
      r.ip_src    = h.inner_ip_src;
      r.ip_dst    = h.inner_ip_dst;
      r.proto     = h.inner_proto;
      r.udp_dport = h.inner_udp_dport;
    end
    if (r.ip_dst[31:28] != STF_IP_MCAST_NIB && m == STF_UCAST_TRANSLATE) begin
      r.ip_dst = grp;
    end
    return r;
  endfunction : stf_effective

  always_comb begin
    eff       = stf_effective(hdr_reg, ucast_mode_i, ucast_group_i);
    hit       = 1'b0;
    hit_idx   = '0;
    // Lowest index wins when two rules carry the same group
    for (int i = NR - 1; i >= 0; i--) begin
      if (rules_reg[i].valid && rules_reg[i].group_ip == eff.ip_dst) begin
        hit     = 1'b1;
        hit_idx = IW'(i);
      end
    end
    meter_len = 20'(hdr_reg.payload_len) + STF_L3L4_BYTES;
    acl_ok    = eff.proto == acl_i.proto && eff.udp_dport >= acl_i.port_lo
                && eff.udp_dport <= acl_i.port_hi;
    src_ok    = !acl_i.src_check_en
                || ((eff.ip_src & acl_i.trusted_mask)
                    == (acl_i.trusted_src & acl_i.trusted_mask));
    rate_ok   = tokens_reg[hit_idx] >= meter_len;
    accept    = hdr_reg.ethertype == STF_ETYPE_IP && acl_ok && src_ok
                && hit && rate_ok;
  end

  always_comb begin
    cfg_conflict = 1'b0;
    for (int j = 0; j < NR; j++) begin
      if (IW'(j) != cfg_idx_i && rules_reg[j].valid
          && rules_reg[j].group_ip == cfg_rule_i.group_ip
          && rules_reg[j].tunnel_mac != cfg_rule_i.tunnel_mac) begin
        cfg_conflict = 1'b1;
      end
    end
    cfg_bad = cfg_rule_i.valid
              && (cfg_conflict
                  || (!cfg_rule_i.tunnel_mac[40] && !cfg_rule_i.basic_mode)
                  || cfg_rule_i.rate_bytes > STF_HOST_BYTES_PER_TICK
                  || 32'(cfg_rule_i.channel) >= NUM_CH);
  end

  // Each rule holds a single broadcast client identifier field
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < NR; k++) begin
        rules_reg[k] <= '0;
      end
      cfg_err_reg <= 1'b0;
    end else begin
      cfg_err_reg <= cfg_we_i && cfg_bad;
      if (cfg_we_i && !cfg_bad) begin
        rules_reg[cfg_idx_i] <= cfg_rule_i;
      end
    end
  end

  assign tick = tick_cnt_reg == '0;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= TW'(TICK_CYCLES - 1);
    end else if (tick) begin
      tick_cnt_reg <= TW'(TICK_CYCLES - 1);
    end else begin
      tick_cnt_reg <= tick_cnt_reg - 1'b1;
    end
  end

  // Token buckets: refill each tick up to the burst size, charge accepted frames
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < NR; k++) begin
        tokens_reg[k] <= STF_TOKENS_RESET;
      end
    end else begin
      for (int k = 0; k < NR; k++) begin
        logic [20:0] t;
        t = {1'b0, tokens_reg[k]};
        if (state_reg == S_CHECK && accept && hit_idx == IW'(k)) begin
          t = t - {1'b0, meter_len};
        end
        if (tick) begin
          t = t + 21'(rules_reg[k].rate_bytes);
          if (t > {1'b0, rules_reg[k].burst_bytes}) begin
            t = {1'b0, rules_reg[k].burst_bytes};
          end
        end
        if (!rules_reg[k].valid) begin
          t = '0;
        end
        tokens_reg[k] <= t[19:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (in_hdr_valid_i) begin
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          state_reg <= accept ? S_HDR : S_BODY;
        end
        S_HDR: begin
          if (out_hdr_ready_i) begin
            state_reg <= S_BODY;
          end
        end
        S_BODY: begin
          if (in_pay_valid_i && in_pay_ready_o && in_pay_i.last) begin
            state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hdr_reg <= '0;
    end else if (state_reg == S_IDLE && in_hdr_valid_i) begin
      hdr_reg <= in_hdr_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_hdr_reg <= '0;
      pass_reg    <= 1'b0;
      drop_reg    <= 1'b0;
    end else begin
      drop_reg <= state_reg == S_CHECK && !accept;
      if (state_reg == S_CHECK) begin
        pass_reg                <= accept;
        out_hdr_reg.fc          <= STF_FC_PACKET_PDU;
        out_hdr_reg.channel     <= rules_reg[hit_idx].channel;
        out_hdr_reg.dst_mac     <= rules_reg[hit_idx].tunnel_mac;
        out_hdr_reg.src_mac     <= hfc_mac_i;
        out_hdr_reg.ethertype   <= hdr_reg.ethertype;
        out_hdr_reg.ip_src      <= eff.ip_src;
        out_hdr_reg.ip_dst      <= eff.ip_dst;
        out_hdr_reg.proto       <= eff.proto;
        out_hdr_reg.udp_dport   <= eff.udp_dport;
        out_hdr_reg.payload_len <= hdr_reg.payload_len;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_pay_valid_reg <= 1'b0;
      out_pay_reg       <= '0;
    end else if (state_reg == S_BODY && pass_reg && in_pay_valid_i && in_pay_ready_o) begin
      out_pay_valid_reg <= 1'b1;
      out_pay_reg       <= in_pay_i;
    end else if (out_pay_ready_i) begin
      out_pay_valid_reg <= 1'b0;
    end
  end

  assign in_hdr_ready_o  = state_reg == S_IDLE;
  assign in_pay_ready_o  = state_reg == S_BODY
                           && (!pass_reg || !out_pay_valid_reg || out_pay_ready_i);
  assign out_hdr_valid_o = state_reg == S_HDR;
  assign out_hdr_o       = out_hdr_reg;
  assign out_pay_valid_o = out_pay_valid_reg;
  assign out_pay_o       = out_pay_reg;
  assign cfg_err_o       = cfg_err_reg;
  assign drop_o          = drop_reg;

  sequence seq_hdr_taken;
    in_hdr_valid_i && in_hdr_ready_o;
  endsequence

  sequence seq_check_to_hdr;
    state_reg == S_CHECK && accept ##1 out_hdr_valid_o;
  endsequence

  a_etype_only_ip: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    out_hdr_valid_o |-> out_hdr_o.ethertype == STF_ETYPE_IP)
    else $error("non-IP frame offered to a tunnel");

  a_fc_packet_pdu: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    out_hdr_valid_o |-> out_hdr_o.fc == STF_FC_PACKET_PDU)
    else $error("frame control not packet PDU");

  a_mac_rewrite: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    seq_check_to_hdr |-> out_hdr_o.src_mac == $past(hfc_mac_i)
      && out_hdr_o.dst_mac == $past(rules_reg[hit_idx].tunnel_mac))
    else $error("MAC header not rewritten");

  a_ip_fields_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    seq_hdr_taken ##1 (accept && hdr_reg.proto != STF_PROTO_GRE
      && hdr_reg.ip_dst[31:28] == STF_IP_MCAST_NIB)
      |=> out_hdr_o.ip_src == $past(hdr_reg.ip_src)
      && out_hdr_o.ip_dst == $past(hdr_reg.ip_dst)
      && out_hdr_o.proto == $past(hdr_reg.proto))
    else $error("IP addresses or protocol altered");

  a_payload_same: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == S_BODY && pass_reg && in_pay_valid_i && in_pay_ready_o)
      |=> out_pay_valid_o && out_pay_o == $past(in_pay_i))
    else $error("payload byte changed or lost");

  a_drop_silent: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == S_CHECK && !accept) |=> drop_o && !out_hdr_valid_o
      ##1 (!out_hdr_valid_o && !drop_o))
    else $error("rejected packet produced a frame");

  a_cfg_dup_reject: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cfg_we_i && cfg_rule_i.valid && cfg_conflict)
      |=> cfg_err_o && rules_reg[$past(cfg_idx_i)] == $past(rules_reg[cfg_idx_i]))
    else $error("group mapped to a second tunnel address");

  a_group_mac: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cfg_we_i && cfg_rule_i.valid && !cfg_rule_i.basic_mode && !cfg_rule_i.tunnel_mac[40])
      |=> cfg_err_o)
    else $error("individual MAC accepted as tunnel address");

  a_rate_tokens: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_reg == S_CHECK && accept && !tick && !cfg_we_i)
      |=> tokens_reg[$past(hit_idx)] == $past(tokens_reg[hit_idx]) - $past(meter_len))
    else $error("frame forwarded beyond its tunnel rate");

  a_host_ceiling: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cfg_we_i && cfg_rule_i.valid && cfg_rule_i.rate_bytes > STF_HOST_BYTES_PER_TICK)
      |=> cfg_err_o)
    else $error("tunnel rate above host ceiling accepted");

  a_hdr_handshake: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    seq_hdr_taken |=> !in_hdr_ready_o ##1 (out_hdr_valid_o || state_reg == S_BODY))
    else $error("header sequencing broken");

endmodule : stf_forwarder

// ### test/stf_sink_model.sv
`timescale 1ns/1ns
module stf_sink_model (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic stall_en_i,
  output logic      hdr_ready_o,
  output logic      pay_ready_o
);
  logic [7:0] lfsr_reg;
  // Consumer only accepts; it never answers upstream
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lfsr_reg    <= 8'hA5;
      hdr_ready_o <= 1'b0;
      pay_ready_o <= 1'b0;
    end else begin
      lfsr_reg    <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      hdr_ready_o <= !stall_en_i || lfsr_reg[0];
      pay_ready_o <= !stall_en_i || lfsr_reg[2];
    end
  end
endmodule : stf_sink_model

// ### test/testbench.sv
`timescale 1ns/1ns
module testbench;
  import stf_pkg::*;
  localparam int TICKS = 20;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, cfg_we = 1'b0, cfg_err, stall_en = 1'b0;
  logic [5:0] cfg_idx = 6'h00;
  stf_rule_type cfg_rule = '0;
  stf_acl_type acl = '0;
  stf_ucast_type ucast_mode = STF_UCAST_DIRECT;
  logic [31:0] ucast_group = 32'hE0000101;
  logic [47:0] hfc_mac = 48'h020000C0FFEE;
  logic in_hdr_valid = 1'b0, in_hdr_ready, in_pay_valid = 1'b0, in_pay_ready;
  stf_hdr_type in_hdr = '0;
  stf_beat_type in_pay = '0, out_pay;
  logic out_hdr_valid, out_hdr_ready, out_pay_valid, out_pay_ready, drop;
  stf_out_hdr_type out_hdr;
  int num_errors = 0, total_checks = 0, drops = 0;
  logic [31:0] rng_state = 32'h0000C965;
  stf_out_hdr_type hdr_q[$];
  stf_beat_type beat_q[$];

  always #2 sys_clk_i = ~sys_clk_i;

  stf_forwarder #(.NUM_CH(2), .RULES_PER_CH(32), .TICK_CYCLES(TICKS)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_we_i(cfg_we), .cfg_idx_i(cfg_idx),
    .cfg_rule_i(cfg_rule), .cfg_err_o(cfg_err), .acl_i(acl), .ucast_mode_i(ucast_mode),
    .ucast_group_i(ucast_group), .hfc_mac_i(hfc_mac), .in_hdr_valid_i(in_hdr_valid),
    .in_hdr_ready_o(in_hdr_ready), .in_hdr_i(in_hdr), .in_pay_valid_i(in_pay_valid),
    .in_pay_ready_o(in_pay_ready), .in_pay_i(in_pay), .out_hdr_valid_o(out_hdr_valid),
    .out_hdr_ready_i(out_hdr_ready), .out_hdr_o(out_hdr), .out_pay_valid_o(out_pay_valid),
    .out_pay_ready_i(out_pay_ready), .out_pay_o(out_pay), .drop_o(drop));

  stf_sink_model u_sink (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .stall_en_i(stall_en),
    .hdr_ready_o(out_hdr_ready), .pay_ready_o(out_pay_ready));

  always @(posedge sys_clk_i) begin
    if (out_hdr_valid === 1'b1 && out_hdr_ready === 1'b1) hdr_q.push_back(out_hdr);
    if (out_pay_valid === 1'b1 && out_pay_ready === 1'b1) beat_q.push_back(out_pay);
    if (drop === 1'b1) drops++;
  end

  function automatic logic [31:0] rnd();
    rng_state ^= rng_state << 13;
    rng_state ^= rng_state >> 17;
    rng_state ^= rng_state << 5;
    return rng_state;
  endfunction : rnd

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      num_errors++;
      $display("mismatch handshake expected done seen timeout");
      final_report();
    end
  endtask : tmo

  function automatic stf_rule_type mk_rule(logic [31:0] g, logic [47:0] m, logic [3:0] ch,
                                           logic b, logic [15:0] r, logic [19:0] bu);
    stf_rule_type x;
    x = '{1'b1, g, m, ch, b, 16'(rnd()), r, bu};
    return x;
  endfunction : mk_rule

  task automatic cfg_write(input logic [5:0] idx, input stf_rule_type r, input logic err);
    cfg_we   <= 1'b1;
    cfg_idx  <= idx;
    cfg_rule <= r;
    @(posedge sys_clk_i);
    cfg_we <= 1'b0;
    #1 check("cfg_err", cfg_err, err);
    @(posedge sys_clk_i);
  endtask : cfg_write

  // Small payloads keep each datagram far below fragmentation size
  function automatic stf_hdr_type mk_hdr(logic [7:0] pr, logic [31:0] src, logic [31:0] dst);
    stf_hdr_type h;
    h = '0;
    h.dst_mac = {16'h0000, rnd()};
    h.src_mac = {16'h0002, rnd()};
    h.ethertype = STF_ETYPE_IP;
    {h.ip_src, h.inner_ip_src, h.ip_dst, h.inner_ip_dst} = {src, src, dst, dst};
    h.proto = pr;
    h.inner_proto = 8'h11;
    h.udp_dport = 16'h1000 | 16'(rnd() & 32'hFFF);
    h.inner_udp_dport = h.udp_dport;
    h.payload_len = 16'(1 + rnd() % 8);
    return h;
  endfunction : mk_hdr

  task automatic send_pkt(input stf_hdr_type h, input logic fwd, input logic [3:0] ch,
                          input logic [47:0] mac, input logic [31:0] dst);
    stf_beat_type sent[$];
    stf_beat_type b;
    stf_out_hdr_type e;
    logic gre;
    int k, h0, b0, d0;
    {h0, b0, d0} = {hdr_q.size(), beat_q.size(), drops};
    gre = (h.proto == STF_PROTO_GRE);
    e = '{STF_FC_PACKET_PDU, ch, mac, hfc_mac, h.ethertype, gre ? h.inner_ip_src : h.ip_src,
          dst, gre ? h.inner_proto : h.proto, gre ? h.inner_udp_dport : h.udp_dport,
          h.payload_len};
    in_hdr <= h;
    in_hdr_valid <= 1'b1;
    k = 0;
    do begin @(posedge sys_clk_i); k++; end while (in_hdr_ready !== 1'b1 && k < 200);
    tmo(k, 200);
    in_hdr_valid <= 1'b0;
    for (int i = 0; i < h.payload_len; i++) begin
      b = '{i == h.payload_len - 1, 8'(rnd())};
      sent.push_back(b);
      in_pay <= b;
      in_pay_valid <= 1'b1;
      k = 0;
      do begin @(posedge sys_clk_i); k++; end while (in_pay_ready !== 1'b1 && k < 200);
      tmo(k, 200);
    end
    in_pay_valid <= 1'b0;
    k = 0;
    while (k < 200 && (fwd ? beat_q.size() < b0 + sent.size() : drops == d0)) begin
      @(posedge sys_clk_i);
      k++;
    end
    tmo(k, 200);
    repeat (4) @(posedge sys_clk_i);
    check("drop", 256'(drops - d0), 256'(!fwd));
    check("frames", 256'(hdr_q.size() - h0), 256'(fwd));
    if (fwd && hdr_q.size() > h0) begin
      check("header", hdr_q[h0], e);
      foreach (sent[i]) check("beat", beat_q[b0 + i], sent[i]);
    end
  endtask : send_pkt

  initial begin
    stf_hdr_type h;
    acl = '{8'h11, 16'h1000, 16'h1FFF, 1'b0, 32'h0A0A0000, 32'hFFFF0000};
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    cfg_write(6'h00, mk_rule(32'hE0000101, 48'h01005E000101, 4'h0, 1'b0, 16'h00C8,
              20'h003E8), 1'b0);
    cfg_write(6'h32, mk_rule(32'hE0000202, 48'h000A0B0C0D0E, 4'h1, 1'b1, 16'h00C8,
              20'h003E8), 1'b0);
    cfg_write(6'h02, mk_rule(32'h0A000005, 48'h01005E00AAAA, 4'h1, 1'b0, 16'h00C8,
              20'h003E8), 1'b0);
    cfg_write(6'h03, mk_rule(32'hE0000303, 48'h01005E000303, 4'h1, 1'b0, 16'h000A,
              20'h00028), 1'b0);
    cfg_write(6'h04, mk_rule(32'hE0000404, 48'h000A0B0C0D0F, 4'h0, 1'b0, 16'h000A,
              20'h00028), 1'b1);
    cfg_write(6'h04, mk_rule(32'hE0000404, 48'h01005E000404, 4'h0, 1'b0, 16'h0101,
              20'h00028), 1'b1);
    cfg_write(6'h04, mk_rule(32'hE0000404, 48'h01005E000404, 4'h2, 1'b0, 16'h000A,
              20'h00028), 1'b1);
    cfg_write(6'h04, mk_rule(32'hE0000101, 48'h01005E000999, 4'h0, 1'b0, 16'h000A,
              20'h00028), 1'b1);
    cfg_write(6'h04, '0, 1'b0);
    for (int i = 0; i < 32; i++)
      cfg_write(6'(16 + i), mk_rule(32'hE0010000 + i, 48'h01005E010000 + i, 4'h0, 1'b0,
                16'h0064, 20'h001F4), 1'b0);
    $display("test config done");
    repeat (10 * TICKS) @(posedge sys_clk_i);
    send_pkt(mk_hdr(8'h11, 32'h0A0A0007, 32'hE001001F), 1, 4'h0, 48'h01005E01001F,
             32'hE001001F);
    h = mk_hdr(8'h11, 32'h0A0A0001, 32'hE0000303);
    h.payload_len = 16'h000D;
    send_pkt(h, 0, 4'h1, 48'h01005E000303, 32'hE0000303);
    h.payload_len = 16'h000C;
    send_pkt(h, 1, 4'h1, 48'h01005E000303, 32'hE0000303);
    $display("test rate done");
    h = mk_hdr(8'h11, 32'h0A0A0001, 32'hE0000101);
    h.ethertype = 16'h86DD;
    send_pkt(h, 0, 4'h0, 48'h01005E000101, 32'hE0000101);
    send_pkt(mk_hdr(8'h06, 32'h0A0A0001, 32'hE0000101), 0, 4'h0, 48'h0, 32'h0);
    h = mk_hdr(8'h11, 32'h0A0A0001, 32'hE0000101);
    h.udp_dport = 16'h2000;
    send_pkt(h, 0, 4'h0, 48'h0, 32'h0);
    send_pkt(mk_hdr(8'h11, 32'h0A0A0001, 32'hE0000999), 0, 4'h0, 48'h0, 32'h0);
    acl.src_check_en <= 1'b1;
    send_pkt(mk_hdr(8'h11, 32'h0B000001, 32'hE0000101), 0, 4'h0, 48'h0, 32'h0);
    send_pkt(mk_hdr(8'h11, 32'h0A0A0002, 32'hE0000101), 1, 4'h0, 48'h01005E000101,
             32'hE0000101);
    $display("test filter done");
    h = mk_hdr(STF_PROTO_GRE, 32'h0A0A0003, 32'hE0000202);
    h.ip_dst = 32'h0A000005;
    h.udp_dport = 16'h0000;
    send_pkt(h, 1, 4'h1, 48'h000A0B0C0D0E, 32'hE0000202);
    send_pkt(mk_hdr(8'h11, 32'h0A0A0004, 32'h0A000005), 1, 4'h1, 48'h01005E00AAAA,
             32'h0A000005);
    ucast_mode <= STF_UCAST_TRANSLATE;
    send_pkt(mk_hdr(8'h11, 32'h0A0A0005, 32'h0A000077), 1, 4'h0, 48'h01005E000101,
             32'hE0000101);
    $display("test unicast done");
    stall_en <= 1'b1;
    repeat (8) send_pkt(mk_hdr(8'h11, 32'h0A0A0000 | (rnd() & 32'hFFFF), 32'hE0000101), 1, 4'h0,
                        48'h01005E000101, 32'hE0000101);
    $display("test random done");
    final_report();
  end
endmodule : testbench
